// File: rtl/dps_pkg.sv
/*
  constants for the drive protection supervisor: register offsets,
  reset values, field positions and timing counts.
  assumes a single 20 MHz control clock.
*/
package dps_pkg;
  localparam int CLK_HZ = 20000000;
  localparam logic [24:0] CLK_HZ_W = 25'(CLK_HZ);
  localparam int FAN_OFF_S = 30;
  localparam int FAN_OFF_CYCLES = FAN_OFF_S * CLK_HZ;
  localparam int PI_TICK_MS = 1;
  localparam int PI_TICK_CYCLES = PI_TICK_MS * (CLK_HZ / 1000);
  localparam logic [7:0] A_CL_MODE = 8'h00;
  localparam logic [7:0] A_CL_THR = 8'h04;
  localparam logic [7:0] A_CL_DROP = 8'h08;
  localparam logic [7:0] A_PL_EN = 8'h0C;
  localparam logic [7:0] A_UV_VKP = 8'h10;
  localparam logic [7:0] A_UV_VKI = 8'h14;
  localparam logic [7:0] A_UV_CKP = 8'h18;
  localparam logic [7:0] A_UV_CKI = 8'h1C;
  localparam logic [7:0] A_FAN_MODE = 8'h20;
  localparam logic [7:0] A_BRK_EN = 8'h24;
  localparam logic [7:0] A_BRK_THR = 8'h28;
  localparam logic [7:0] A_BRK_STOP = 8'h2C;
  localparam logic [7:0] A_STO_LOCK = 8'h30;
  localparam logic [7:0] A_STO_EN = 8'h34;
  localparam logic [7:0] A_ACC_RATE = 8'h38;
  localparam logic [7:0] A_LOW_LIM = 8'h3C;
  localparam logic [7:0] A_PL_VOLT = 8'h40;
  localparam logic [7:0] A_STATUS = 8'h44;
  localparam logic [7:0] A_OUT_FREQ = 8'h48;
  localparam logic [7:0] A_CTRL = 8'h4C;
  localparam logic [7:0] R_CL_MODE = 8'h01;
  localparam logic [15:0] R_CL_THR = 16'h0640;
  localparam logic [15:0] R_CL_DROP = 16'h03E8;
  localparam logic [15:0] R_UV_VKP = 16'h0014;
  localparam logic [15:0] R_UV_VKI = 16'h0005;
  localparam logic [15:0] R_UV_CKP = 16'h0014;
  localparam logic [15:0] R_UV_CKI = 16'h0014;
  localparam logic [15:0] R_BRK_THR = 16'h1B58;
  localparam logic [15:0] R_ACC_RATE = 16'h03E8;
  localparam logic [15:0] R_LOW_LIM = 16'h0000;
  localparam logic [15:0] R_PL_VOLT = 16'h1770;
  localparam logic [15:0] BRK_HYST = 16'h0064;
  localparam logic [7:0] FAN_HOT_C = 8'h32;
  localparam logic [15:0] RATE_MAX = 16'h1388;
  localparam int CLM_ACT_BIT = 0;
  localparam int CLM_NOALM_BIT = 4;
  localparam logic [1:0] FAN_ALWAYS = 2'h1;
  localparam logic [1:0] FAN_RAMP = 2'h2;
  localparam int ST_FAN = 0;
  localparam int ST_BRAKE = 1;
  localparam int ST_GATE = 2;
  localparam int ST_STO = 3;
  localparam int ST_HWALM = 4;
  localparam int ST_CLHOLD = 5;
  localparam int ST_CLDROP = 6;
  localparam int ST_PLACT = 7;
  localparam int CTRL_RESET_BIT = 0;
  typedef enum {CL_IDLE, CL_HOLD, CL_DROP} dps_cl_type;
endpackage

// File: rtl/dps_top.sv
/*
  drive protection supervisor: current limit, power-loss frequency drop,
  fan control, dynamic braking and safe torque off, with a classic
  wishbone register slave. measurements and run state come from logic on
  sys_clk; mainsFail and stoRequest come from pins and are synchronised.
*/
// Notes on behaviour
// - accelerating and over current limit: hold output frequency.
// - constant speed and over current limit: reduce output frequency.
// - keep reducing at drop rate while over limit, not below lower limit.
// - current back under limit: resume normal acceleration to set frequency.
// - mode ones digit enables limiting; tens digit disables hardware alarm.
// - threshold in 0.1 percent of rated current, default 160.0 percent.
// - power loss enabled and mains lost: lower frequency to hold bus voltage.
// - power-loss regulator uses voltage and current proportional, integral gains.
// - any fan mode: fan runs when module temperature reaches 50 degrees.
// - fan mode 0: fan on while running, off 30 s after stop.
// - fan mode 1: fan always on while powered.
// - fan mode 2: on while running above zero ramp, off 30 s after.
// - braking and stop braking enabled: brake above threshold, running or not.
// - braking enabled, stop braking disabled: brake above threshold only running.
// - brake off when bus falls below threshold minus 10 V.
// - brake threshold in 0.1 V, default 700.0 V.
// - safe torque off active: remove all gate drive.
// - lock setting 0: alarm latched until explicit reset.
// - lock setting 1: alarm clears once input condition restores.
`timescale 1ns/100ps
module dps_top #(
  parameter int FAN_OFF_CYCLES = dps_pkg::FAN_OFF_CYCLES,
  parameter int PI_TICK_CYCLES = dps_pkg::PI_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic runCmd,
  input wire logic [15:0] setFreq,
  input wire logic [15:0] outCurrent,
  input wire logic [15:0] busVoltage,
  input wire logic [7:0] rectTemp,
  input wire logic [7:0] invTemp,
  input wire logic hwLimitEvent,
  input wire logic mainsFail,
  input wire logic stoRequest,
  output logic [15:0] outFreq,
  output logic fanOn,
  output logic brakeOn,
  output logic gateEnable,
  output logic stoAlarm,
  output logic hwLimitAlarm
);
  import dps_pkg::*;

  logic [7:0] clMode_q;
  logic [15:0] clThr_q;
  logic [15:0] clDrop_q;
  logic [15:0] vKp_q;
  logic [15:0] vKi_q;
  logic [15:0] cKp_q;
  logic [15:0] cKi_q;
  logic [15:0] brkThr_q;
  logic [15:0] accRate_q;
  logic [15:0] lowLim_q;
  logic [15:0] plVolt_q;
  logic plEn_q;
  logic brkEn_q;
  logic brkStop_q;
  logic stoLock_q;
  logic stoEn_q;
  logic [1:0] fanMode_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic alarmReset;
  logic [1:0] mainsSync_q;
  logic [1:0] stoSync_q;
  logic [15:0] freq_q;
  logic [24:0] acc_q;
  logic fan_q;
  logic brake_q;
  logic gate_q;
  logic sto_q;
  logic hwAlm_q;
  logic [31:0] fanCnt_q;
  logic [31:0] tick_q;
  logic [31:0] vInt_q;
  logic [31:0] cInt_q;
  logic plActive;
  dps_cl_type cl_q;

  function automatic logic [15:0] mrg(input logic [15:0] old, input logic [31:0] d,
                                      input logic [3:0] s);
    mrg = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  wire wbReq = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wbWr = wbReq & wb_we_i;

  // bus answer: registered ack one cycle after the request, ack for every address
  always_ff @(posedge sys_clk)
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= wbReq;

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      clMode_q <= R_CL_MODE;
      clThr_q <= R_CL_THR;
      clDrop_q <= R_CL_DROP;
      plEn_q <= 1'b0;
      vKp_q <= R_UV_VKP;
      vKi_q <= R_UV_VKI;
      cKp_q <= R_UV_CKP;
      cKi_q <= R_UV_CKI;
      fanMode_q <= 2'h0;
      brkEn_q <= 1'b0;
      brkThr_q <= R_BRK_THR;
      brkStop_q <= 1'b0;
      stoLock_q <= 1'b0;
      stoEn_q <= 1'b0;
      accRate_q <= R_ACC_RATE;
      lowLim_q <= R_LOW_LIM;
      plVolt_q <= R_PL_VOLT;
    end
    else if (wbWr)
    begin
      case (wb_adr_i)
        A_CL_MODE: if (wb_sel_i[0]) clMode_q <= wb_dat_i[7:0];
        A_CL_THR: clThr_q <= mrg(clThr_q, wb_dat_i, wb_sel_i);
        A_CL_DROP: clDrop_q <= mrg(clDrop_q, wb_dat_i, wb_sel_i);
        A_PL_EN: if (wb_sel_i[0]) plEn_q <= wb_dat_i[0];
        A_UV_VKP: vKp_q <= mrg(vKp_q, wb_dat_i, wb_sel_i);
        A_UV_VKI: vKi_q <= mrg(vKi_q, wb_dat_i, wb_sel_i);
        A_UV_CKP: cKp_q <= mrg(cKp_q, wb_dat_i, wb_sel_i);
        A_UV_CKI: cKi_q <= mrg(cKi_q, wb_dat_i, wb_sel_i);
        A_FAN_MODE: if (wb_sel_i[0]) fanMode_q <= wb_dat_i[1:0];
        A_BRK_EN: if (wb_sel_i[0]) brkEn_q <= wb_dat_i[0];
        A_BRK_THR: brkThr_q <= mrg(brkThr_q, wb_dat_i, wb_sel_i);
        A_BRK_STOP: if (wb_sel_i[0]) brkStop_q <= wb_dat_i[0];
        A_STO_LOCK: if (wb_sel_i[0]) stoLock_q <= wb_dat_i[0];
        A_STO_EN: if (wb_sel_i[0]) stoEn_q <= wb_dat_i[0];
        A_ACC_RATE: accRate_q <= mrg(accRate_q, wb_dat_i, wb_sel_i);
        A_LOW_LIM: lowLim_q <= mrg(lowLim_q, wb_dat_i, wb_sel_i);
        A_PL_VOLT: plVolt_q <= mrg(plVolt_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end

  assign alarmReset = wbWr & (wb_adr_i == A_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_RESET_BIT];

  always_ff @(posedge sys_clk)
    if (rst)
      rdat_q <= 32'h0;
    else if (wbReq & ~wb_we_i)
    begin
      case (wb_adr_i)
        A_CL_MODE: rdat_q <= {24'h0, clMode_q};
        A_CL_THR: rdat_q <= {16'h0, clThr_q};
        A_CL_DROP: rdat_q <= {16'h0, clDrop_q};
        A_PL_EN: rdat_q <= {31'h0, plEn_q};
        A_UV_VKP: rdat_q <= {16'h0, vKp_q};
        A_UV_VKI: rdat_q <= {16'h0, vKi_q};
        A_UV_CKP: rdat_q <= {16'h0, cKp_q};
        A_UV_CKI: rdat_q <= {16'h0, cKi_q};
        A_FAN_MODE: rdat_q <= {30'h0, fanMode_q};
        A_BRK_EN: rdat_q <= {31'h0, brkEn_q};
        A_BRK_THR: rdat_q <= {16'h0, brkThr_q};
        A_BRK_STOP: rdat_q <= {31'h0, brkStop_q};
        A_STO_LOCK: rdat_q <= {31'h0, stoLock_q};
        A_STO_EN: rdat_q <= {31'h0, stoEn_q};
        A_ACC_RATE: rdat_q <= {16'h0, accRate_q};
        A_LOW_LIM: rdat_q <= {16'h0, lowLim_q};
        A_PL_VOLT: rdat_q <= {16'h0, plVolt_q};
        A_STATUS: rdat_q <= {24'h0, plActive, cl_q == CL_DROP, cl_q == CL_HOLD, hwAlm_q,
                             sto_q, gate_q, brake_q, fan_q};
        A_OUT_FREQ: rdat_q <= {16'h0, freq_q};
        default: rdat_q <= 32'h0;
      endcase
    end

  // pin inputs pass two flip-flops
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      mainsSync_q <= 2'b00;
      stoSync_q <= 2'b00;
    end
    else
    begin
      mainsSync_q <= {mainsSync_q[0], mainsFail};
      stoSync_q <= {stoSync_q[0], stoRequest};
    end

  wire mainsLost = mainsSync_q[1];
  wire stoReq = stoSync_q[1] & stoEn_q;
  wire overLimit = outCurrent > clThr_q;
  wire clOn = clMode_q[CLM_ACT_BIT];

  // current-limit state
  always_ff @(posedge sys_clk)
    if (rst)
      cl_q <= CL_IDLE;
    else
    begin
      case (cl_q)
        CL_IDLE:
          if (clOn & runCmd & overLimit)
            cl_q <= (freq_q < setFreq) ? CL_HOLD : CL_DROP;
        CL_HOLD, CL_DROP:
          if (~overLimit | ~clOn | ~runCmd)
            cl_q <= CL_IDLE;
        default: cl_q <= CL_IDLE;
      endcase
    end

  // power-loss regulator, updated once per tick
  assign plActive = plEn_q & mainsLost & runCmd & gate_q;
  wire [15:0] vErr = (busVoltage < plVolt_q) ? 16'(plVolt_q - busVoltage) : 16'h0;
  wire [31:0] vOut = 32'((vKp_q * vErr + vInt_q) >> 8);
  wire [31:0] cOut = 32'(((cKp_q * vOut[15:0]) >> 4) + cInt_q);
  wire [15:0] plRate = (cOut[31:8] > 24'(RATE_MAX)) ? RATE_MAX : cOut[23:8];
  wire tick = tick_q == 32'h0;

  always_ff @(posedge sys_clk)
    if (rst)
      tick_q <= 32'h0;
    else
      tick_q <= tick ? 32'(PI_TICK_CYCLES - 1) : tick_q - 32'h1;

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      vInt_q <= 32'h0;
      cInt_q <= 32'h0;
    end
    else if (~plActive | vErr == 16'h0)
    begin
      vInt_q <= 32'h0;
      cInt_q <= 32'h0;
    end
    else if (tick)
    begin
      vInt_q <= vInt_q[31:24] != 8'h0 ? vInt_q : vInt_q + vKi_q * vErr;
      cInt_q <= cInt_q[31:24] != 8'h0 ? cInt_q : cInt_q + ((cKi_q * vOut[15:0]) >> 8);
    end

  // frequency ramp: rate in 0.01 Hz/s, step of 0.01 Hz
  logic [15:0] rate, target;
  logic goUp, goDown;
  always_comb
  begin
    rate = accRate_q;
    target = runCmd ? setFreq : 16'h0;
    goUp = freq_q < target;
    goDown = freq_q > target;
    if (plActive)
    begin
      rate = plRate;
      target = 16'h0;
      goUp = 1'b0;
      goDown = vErr != 16'h0;
    end
    else if (cl_q == CL_HOLD)
    begin
      goUp = 1'b0;
      goDown = 1'b0;
    end
    else if (cl_q == CL_DROP)
    begin
      rate = clDrop_q;
      target = lowLim_q;
      goUp = 1'b0;
      goDown = freq_q > lowLim_q;
    end
  end

  wire [24:0] accSum = acc_q + 25'(rate);
  wire step = accSum >= CLK_HZ_W;

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      acc_q <= 25'h0;
      freq_q <= 16'h0;
    end
    else if (~gate_q)
    begin
      acc_q <= 25'h0;
      freq_q <= 16'h0;
    end
    else if (goUp | goDown)
    begin
      acc_q <= step ? accSum - CLK_HZ_W : accSum;
      if (step)
        freq_q <= goUp ? freq_q + 16'h1 : freq_q - 16'h1;
    end
    else
      acc_q <= 25'h0;

  // fan control
  wire hot = (rectTemp >= FAN_HOT_C) | (invTemp >= FAN_HOT_C);
  wire fanRun = (fanMode_q == FAN_RAMP) ? (runCmd & freq_q != 16'h0) : runCmd;

  always_ff @(posedge sys_clk)
    if (rst)
      fanCnt_q <= 32'h0;
    else if (fanRun)
      fanCnt_q <= 32'(FAN_OFF_CYCLES);
    else if (fanCnt_q != 32'h0)
      fanCnt_q <= fanCnt_q - 32'h1;

  always_ff @(posedge sys_clk)
    if (rst)
      fan_q <= 1'b0;
    else
      fan_q <= hot | (fanMode_q == FAN_ALWAYS) | fanRun | (fanCnt_q > 32'h0);

  // braking transistor with hysteresis
  wire brkAllowed = brkEn_q & (brkStop_q | runCmd);
  always_ff @(posedge sys_clk)
    if (rst)
      brake_q <= 1'b0;
    else if (~brkAllowed)
      brake_q <= 1'b0;
    else if (busVoltage > brkThr_q)
      brake_q <= 1'b1;
    else if (busVoltage < brkThr_q - BRK_HYST)
      brake_q <= 1'b0;

  // safe torque off alarm
  always_ff @(posedge sys_clk)
    if (rst)
      sto_q <= 1'b0;
    else if (stoReq)
      sto_q <= 1'b1;
    else if (stoLock_q)
      sto_q <= 1'b0;
    else if (alarmReset)
      sto_q <= 1'b0;

  always_ff @(posedge sys_clk)
    if (rst)
      gate_q <= 1'b0;
    else
      gate_q <= ~stoReq & ~sto_q;

  // hardware current-limit alarm, set wins over reset
  always_ff @(posedge sys_clk)
    if (rst)
      hwAlm_q <= 1'b0;
    else if (hwLimitEvent & ~clMode_q[CLM_NOALM_BIT])
      hwAlm_q <= 1'b1;
    else if (alarmReset)
      hwAlm_q <= 1'b0;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign outFreq = freq_q;
  assign fanOn = fan_q;
  assign brakeOn = brake_q;
  assign gateEnable = gate_q;
  assign stoAlarm = sto_q;
  assign hwLimitAlarm = hwAlm_q;
endmodule // dps_top

// File: sim/dps_chk.sv
/*
  port checker for dps_top, bound to every instance.
  assumes the default brake and current-limit thresholds stay in force.
*/
`timescale 1ns/100ps
module dps_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic runCmd,
  input wire logic [15:0] outCurrent,
  input wire logic [15:0] busVoltage,
  input wire logic [7:0] rectTemp,
  input wire logic hwLimitEvent,
  input wire logic [15:0] outFreq,
  input wire logic fanOn,
  input wire logic brakeOn,
  input wire logic gateEnable,
  input wire logic stoAlarm,
  input wire logic hwLimitAlarm
);
  import dps_pkg::*;
  logic brkEnQ;
  logic brkStopQ;
  logic take;
  logic overCur;
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign overCur = runCmd && (outCurrent > R_CL_THR);
  // shadow of the brake enables, caught at the edge a write is taken
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      brkEnQ <= 1'b0;
      brkStopQ <= 1'b0;
    end
    else if (take)
    begin
      if (wb_adr_i == A_BRK_EN)
        brkEnQ <= wb_dat_i[0];
      if (wb_adr_i == A_BRK_STOP)
        brkStopQ <= wb_dat_i[0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  chk_sto_gate: assert property (stoAlarm |=> !gateEnable)
    else $error("gate drive left on during torque off alarm");
  chk_brake_rise: assert property ($rose(brakeOn) |-> $past(busVoltage) > R_BRK_THR)
    else $error("brake turned on at or below threshold");
  chk_brake_hyst: assert property (brakeOn |-> $past(busVoltage) >= R_BRK_THR - BRK_HYST)
    else $error("brake held on below hysteresis level");
  chk_brake_off: assert property (!brkEnQ |=> !brakeOn)
    else $error("brake on while braking disabled");
  chk_brake_stop: assert property ((!brkStopQ && !runCmd) |=> !brakeOn)
    else $error("brake on while stopped without stop braking");
  chk_fan_hot: assert property ((rectTemp >= FAN_HOT_C) |-> ##[1:2] fanOn)
    else $error("fan off with hot module");
  chk_freq_norise: assert property (overCur [*3] |-> outFreq <= $past(outFreq))
    else $error("frequency rose while over current limit");
  chk_alarm_cause: assert property ($rose(hwLimitAlarm) |-> $past(hwLimitEvent))
    else $error("overload alarm without event");
endmodule // dps_chk
bind dps_top dps_chk u_dps_chk (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .runCmd(runCmd), .outCurrent(outCurrent),
  .busVoltage(busVoltage), .rectTemp(rectTemp), .hwLimitEvent(hwLimitEvent),
  .outFreq(outFreq), .fanOn(fanOn), .brakeOn(brakeOn), .gateEnable(gateEnable),
  .stoAlarm(stoAlarm), .hwLimitAlarm(hwLimitAlarm));

// File: sim/dps_power_stage.sv
/*
  power stage model: bus voltage follows a target, braking pulls it down.
  assumes one clock shared with the supervisor.
*/
`timescale 1ns/100ps
module dps_power_stage (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic brakeOn,
  input wire logic [15:0] busTarget,
  output logic [15:0] busVoltage
);
  // braking resistor drains 8.0 V below the supply level
  always_ff @(posedge sys_clk)
  begin
    if (rst || !brakeOn)
      busVoltage <= busTarget;
    else
      busVoltage <= busTarget - 16'h0050;
  end
endmodule // dps_power_stage

// File: sim/tb_drive_protection_supervisor.sv
/*
  self-checking bench for dps_top with a power stage model.
  assumes short fan delay and register reads as the checked results.
*/
`timescale 1ns/100ps
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin failCount++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module tb_drive_protection_supervisor;
  import dps_pkg::*;
  typedef struct {string n; logic [31:0] e; logic [31:0] m; logic [7:0] a;} dps_note_type;
  dps_note_type notes[$];
  dps_note_type nt;
  logic sys_clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00, rectTemp = 8'h00, invTemp = 8'h00;
  logic [31:0] wbDatW = 32'h00000000, seed = 32'hE40DA13A, wbDat;
  logic [3:0] wbSel = 4'h0;
  logic runCmd = 1'b0, hwLimitEvent = 1'b0, mainsFail = 1'b0, stoRequest = 1'b0;
  logic hot = 1'b0, hotInv = 1'b0, wbAck, fanOn, brakeOn, gateEnable, stoAlarm, hwLimitAlarm;
  logic [4:0] pins;
  logic [15:0] setFreq = 16'h0000, outCurrent = 16'h0100, busTarget = 16'h1518;
  logic [15:0] busVoltage, outFreq;
  int failCount = 0, totalChecks = 0, cycles = 0;
  localparam logic [7:0] RA [15] = '{A_CL_MODE, A_CL_THR, A_CL_DROP, A_PL_EN, A_UV_VKP,
    A_UV_VKI, A_UV_CKP, A_UV_CKI, A_FAN_MODE, A_BRK_EN, A_BRK_THR, A_BRK_STOP,
    A_STO_LOCK, A_STO_EN, 8'h50};
  localparam logic [15:0] RV [15] = '{16'(R_CL_MODE), R_CL_THR, R_CL_DROP, 16'h0000,
    R_UV_VKP, R_UV_VKI, R_UV_CKP, R_UV_CKI, 16'h0000, 16'h0000, R_BRK_THR, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  dps_top #(.FAN_OFF_CYCLES(50), .PI_TICK_CYCLES(4)) u_dps_top (.sys_clk(sys_clk),
    .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDat), .wb_ack_o(wbAck),
    .runCmd(runCmd), .setFreq(setFreq), .outCurrent(outCurrent), .busVoltage(busVoltage),
    .rectTemp(rectTemp), .invTemp(invTemp), .hwLimitEvent(hwLimitEvent),
    .mainsFail(mainsFail), .stoRequest(stoRequest), .outFreq(outFreq), .fanOn(fanOn),
    .brakeOn(brakeOn), .gateEnable(gateEnable), .stoAlarm(stoAlarm),
    .hwLimitAlarm(hwLimitAlarm));
  dps_power_stage u_dps_power_stage (.sys_clk(sys_clk), .rst(rst), .brakeOn(brakeOn),
    .busTarget(busTarget), .busVoltage(busVoltage));
  always #25 sys_clk = ~sys_clk;
  assign pins = {hwLimitAlarm, stoAlarm, gateEnable, brakeOn, fanOn};
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // random cool temperatures, and the run time limit
  always @(posedge sys_clk)
  begin
    seed <= xs(seed);
    rectTemp <= hot ? FAN_HOT_C : seed[7:0] % 8'h32;
    invTemp <= hotInv ? FAN_HOT_C : seed[15:8] % 8'h32;
    cycles++;
    if (cycles == 60000)
    begin
      failCount++;
      complete_run();
    end
  end
  // read answers are matched to the oldest note
  always @(posedge sys_clk)
  begin
    if (wbAck === 1'b1 && !wbWe)
    begin
      nt = notes.pop_front();
      `CHK(nt.n, nt.e & nt.m, wbDat & nt.m)
      if (nt.a == A_STATUS)
        `CHK("status pins", nt.e[4:0] & nt.m[4:0], pins & nt.m[4:0])
      if (nt.a == A_OUT_FREQ)
        `CHK("frequency pin", nt.e[15:0], outFreq)
    end
  end
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= 4'h3;
    @(posedge sys_clk);
    while (wbAck !== 1'b1) @(posedge sys_clk);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbx(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input string n);
    dps_note_type t;
    t.n = n;
    t.e = e;
    t.m = m;
    t.a = a;
    notes.push_back(t);
    wbx(1'b0, a, 32'h00000000);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic st(input int n, input logic [31:0] e, input logic [31:0] m);
    wt(n);
    rd(A_STATUS, e, m, "status");
  endtask
  task automatic pulse;
    hwLimitEvent <= 1'b1;
    wt(1);
    hwLimitEvent <= 1'b0;
  endtask
  initial
  begin
    wt(16);
    rst <= 1'b0;
    wt(2);
    for (int i = 0; i < 15; i++)
      rd(RA[i], 32'(RV[i]), 32'h0000FFFF, "reset value");
    $display("test registers done");
    runCmd <= 1'b1;
    st(5, 32'h01, 32'h01);
    runCmd <= 1'b0;
    st(20, 32'h01, 32'h01);
    runCmd <= 1'b1;
    wt(5);
    runCmd <= 1'b0;
    st(40, 32'h01, 32'h01);
    st(20, 32'h00, 32'h01);
    wr(A_FAN_MODE, 32'h2);
    runCmd <= 1'b1;
    st(10, 32'h00, 32'h01);
    runCmd <= 1'b0;
    wr(A_FAN_MODE, 32'h1);
    st(5, 32'h01, 32'h01);
    wr(A_FAN_MODE, 32'h0);
    st(60, 32'h00, 32'h01);
    hot <= 1'b1;
    st(5, 32'h01, 32'h01);
    hot <= 1'b0;
    hotInv <= 1'b1;
    st(5, 32'h01, 32'h01);
    hotInv <= 1'b0;
    wt(60);
    $display("test fan done");
    wr(A_BRK_EN, 32'h1);
    wr(A_BRK_STOP, 32'h1);
    busTarget <= 16'h1B62;
    st(5, 32'h02, 32'h02);
    st(5, 32'h02, 32'h02);
    busTarget <= 16'h1B26;
    st(5, 32'h00, 32'h02);
    wr(A_BRK_STOP, 32'h0);
    busTarget <= 16'h1B62;
    st(5, 32'h00, 32'h02);
    runCmd <= 1'b1;
    st(5, 32'h02, 32'h02);
    wr(A_BRK_EN, 32'h0);
    st(5, 32'h00, 32'h02);
    busTarget <= 16'h1518;
    $display("test brake done");
    wr(A_ACC_RATE, 32'h1388);
    wr(A_CL_DROP, 32'h1388);
    setFreq <= 16'h0003;
    outCurrent <= 16'h0700;
    wt(6000);
    rd(A_OUT_FREQ, 32'h0, 32'hFFFF, "held frequency");
    outCurrent <= 16'h0640;
    wt(14000);
    rd(A_OUT_FREQ, 32'h3, 32'hFFFF, "resumed frequency");
    wr(A_LOW_LIM, 32'h1);
    outCurrent <= 16'h0700;
    wt(14000);
    rd(A_OUT_FREQ, 32'h1, 32'hFFFF, "dropped frequency");
    st(1, 32'h40, 32'h40);
    wr(A_FAN_MODE, 32'h2);
    st(1, 32'h01, 32'h01);
    wr(A_FAN_MODE, 32'h0);
    outCurrent <= 16'h0100;
    $display("test current limit done");
    wr(A_PL_EN, 32'h1);
    busTarget <= 16'h1388;
    mainsFail <= 1'b1;
    st(10, 32'h80, 32'h80);
    mainsFail <= 1'b0;
    busTarget <= 16'h1518;
    pulse();
    st(3, 32'h10, 32'h10);
    wr(A_CTRL, 32'h1);
    st(1, 32'h00, 32'h10);
    wr(A_CL_MODE, 32'h11);
    pulse();
    st(3, 32'h00, 32'h10);
    $display("test alarm done");
    wr(A_STO_EN, 32'h1);
    stoRequest <= 1'b1;
    st(6, 32'h08, 32'h0C);
    rd(A_OUT_FREQ, 32'h0, 32'hFFFF, "stopped frequency");
    stoRequest <= 1'b0;
    st(6, 32'h08, 32'h0C);
    wr(A_CTRL, 32'h1);
    st(3, 32'h04, 32'h0C);
    wr(A_STO_LOCK, 32'h1);
    stoRequest <= 1'b1;
    st(6, 32'h08, 32'h0C);
    stoRequest <= 1'b0;
    st(6, 32'h04, 32'h0C);
    $display("test torque off done");
    complete_run();
  end
endmodule // tb_drive_protection_supervisor
